// ===== include/dsp_consts.svh
/*
  Pad select encodings and pad indices for the shared DMA/peripheral pad mux.
  Assumes inclusion by the mux module and the testbench only.
*/
`ifndef DSP_CONSTS_SVH
`define DSP_CONSTS_SVH
`define DSP_SEL_GPIO       2'h0
`define DSP_SEL_ALT1       2'h1
`define DSP_SEL_ALT2       2'h2
`define DSP_ISEL_ALT       2'h1
`define DSP_NUM_PADS       13
`define DSP_NUM_CH         4
`define DSP_PAD_REQ0       0
`define DSP_PAD_ACK0       1
`define DSP_PAD_EOT0       2
`define DSP_PAD_REQ1       3
`define DSP_PAD_ACK1       4
`define DSP_PAD_EOT1       5
`define DSP_PAD_REQ2       6
`define DSP_PAD_ACK2       7
`define DSP_PAD_EOT2       8
`define DSP_PAD_REQ3       9
`define DSP_PAD_EOT3       10
`define DSP_PAD_CS1        11
`define DSP_PAD_CS2        12
`endif

// ===== include/dsp_pkg.sv
/*
  Types for the shared pad mux.
  Assumes dsp_consts.svh is on the include path.
*/
package dsp_pkg;
  typedef struct packed {
    logic [1:0] output_select;
    logic [1:0] tristate_select;
    logic [1:0] input_select;
  } dsp_pad_cfg_t;
  typedef struct packed {
    logic o;
    logic oe;
  } dsp_pad_drv_t;
endpackage : dsp_pkg

// ===== src/dsp_pin_mux.sv
/*
  Shared pad mux: DMA request, acknowledge, end-of-transfer/terminal count,
  peripheral address 05:07, peripheral parity 0:2 and chip selects 1:5.
  Assumes configuration comes from system registers on the same clock and
  pads arrive asynchronously; pad resolution is done by the testbench.
*/
`timescale 1ns/1ps
`include "dsp_consts.svh"
module dsp_pin_mux #(
  parameter int NPADS = `DSP_NUM_PADS,
  parameter int NCH   = `DSP_NUM_CH
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire dsp_pkg::dsp_pad_cfg_t     pad_cfg_i [NPADS],
  input  wire logic [NCH-1:0]            eot_direction_select_i,
  input  wire logic [2:0]                nand_ce_grouping_i,
  input  wire logic                      nand_cs0_grouping_i,
  input  wire logic [NPADS-1:0]          pad_in_i,
  output logic      [NPADS-1:0]          pad_out_o,
  output logic      [NPADS-1:0]          pad_oe_o,
  input  wire logic [NCH-1:0]            dma_acknowledge_i,
  input  wire logic [NCH-1:0]            terminal_count_out_i,
  input  wire logic [0:26]               periph_address_i,
  input  wire logic [2:0]                periph_parity_out_i,
  input  wire logic [2:0]                periph_parity_oe_i,
  input  wire logic [1:5]                periph_chip_select_n_i,
  input  wire logic [1:2]                nand_chip_enable_n_i,
  input  wire logic                      periph_chip_select0_n_i,
  input  wire logic                      nand_chip_enable0_n_i,
  output logic                           cs0_pad_n_o,
  output logic      [NCH-1:0]            dma_request_o,
  output logic      [NCH-1:0]            end_of_transfer_in_o,
  output logic      [2:0]                periph_parity_in_o,
  output logic      [NPADS-1:0]          gpio_in_o,
  output logic      [0:26]               periph_address_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [NPADS-1:0] pad_meta;
  logic [NPADS-1:0] pad_sync;
  logic [NPADS-1:0] next_out;
  logic [NPADS-1:0] next_oe;

  function automatic logic both_sel(input dsp_pkg::dsp_pad_cfg_t c,
                                    input logic [1:0] s);
    both_sel = (c.output_select == s) && (c.tristate_select == s);
  endfunction : both_sel

  // Pads are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_meta <= '0;
      pad_sync <= '0;
    end else begin
      pad_meta <= pad_in_i;
      pad_sync <= pad_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive per pad; GPIO select leaves pad undriven here
  always_comb begin
    next_out = '0;
    next_oe  = '0;
    for (int i = 0; i < NPADS; i++) begin
      next_out[i] = 1'b0;
    end
    // Channel 0 pads double as address 05:07
    if (both_sel(pad_cfg_i[`DSP_PAD_REQ0], `DSP_SEL_ALT1)) begin
      next_out[`DSP_PAD_REQ0] = periph_address_i[0];
      next_oe[`DSP_PAD_REQ0]  = 1'b1;
    end
    if (both_sel(pad_cfg_i[`DSP_PAD_ACK0], `DSP_SEL_ALT1)) begin
      next_out[`DSP_PAD_ACK0] = periph_address_i[1];
      next_oe[`DSP_PAD_ACK0]  = 1'b1;
    end else if (both_sel(pad_cfg_i[`DSP_PAD_ACK0], `DSP_SEL_ALT2)) begin
      next_out[`DSP_PAD_ACK0] = dma_acknowledge_i[0];
      next_oe[`DSP_PAD_ACK0]  = 1'b1;
    end
    if (both_sel(pad_cfg_i[`DSP_PAD_EOT0], `DSP_SEL_ALT1)) begin
      next_out[`DSP_PAD_EOT0] = periph_address_i[2];
      next_oe[`DSP_PAD_EOT0]  = 1'b1;
    end else if (both_sel(pad_cfg_i[`DSP_PAD_EOT0], `DSP_SEL_ALT2)) begin
      next_out[`DSP_PAD_EOT0] = terminal_count_out_i[0];
      next_oe[`DSP_PAD_EOT0]  = eot_direction_select_i[0];
    end
    // Channel 1 pads double as chip selects 3:5
    if (both_sel(pad_cfg_i[`DSP_PAD_REQ1], `DSP_SEL_ALT1) && !nand_ce_grouping_i[2]) begin
      next_out[`DSP_PAD_REQ1] = periph_chip_select_n_i[3];
      next_oe[`DSP_PAD_REQ1]  = 1'b1;
    end
    if (both_sel(pad_cfg_i[`DSP_PAD_ACK1], `DSP_SEL_ALT1)) begin
      next_out[`DSP_PAD_ACK1] = periph_chip_select_n_i[4];
      next_oe[`DSP_PAD_ACK1]  = 1'b1;
    end else if (both_sel(pad_cfg_i[`DSP_PAD_ACK1], `DSP_SEL_ALT2)) begin
      next_out[`DSP_PAD_ACK1] = dma_acknowledge_i[1];
      next_oe[`DSP_PAD_ACK1]  = 1'b1;
    end
    if (both_sel(pad_cfg_i[`DSP_PAD_EOT1], `DSP_SEL_ALT1)) begin
      next_out[`DSP_PAD_EOT1] = periph_chip_select_n_i[5];
      next_oe[`DSP_PAD_EOT1]  = 1'b1;
    end else if (both_sel(pad_cfg_i[`DSP_PAD_EOT1], `DSP_SEL_ALT2)) begin
      next_out[`DSP_PAD_EOT1] = terminal_count_out_i[1];
      next_oe[`DSP_PAD_EOT1]  = eot_direction_select_i[1];
    end
    // Channel 2 pads double as parity 0:2
    if (both_sel(pad_cfg_i[`DSP_PAD_REQ2], `DSP_SEL_ALT1)) begin
      next_out[`DSP_PAD_REQ2] = periph_parity_out_i[0];
      next_oe[`DSP_PAD_REQ2]  = periph_parity_oe_i[0];
    end
    if (both_sel(pad_cfg_i[`DSP_PAD_ACK2], `DSP_SEL_ALT1)) begin
      next_out[`DSP_PAD_ACK2] = periph_parity_out_i[1];
      next_oe[`DSP_PAD_ACK2]  = periph_parity_oe_i[1];
    end else if (both_sel(pad_cfg_i[`DSP_PAD_ACK2], `DSP_SEL_ALT2)) begin
      next_out[`DSP_PAD_ACK2] = dma_acknowledge_i[2];
      next_oe[`DSP_PAD_ACK2]  = 1'b1;
    end
    if (both_sel(pad_cfg_i[`DSP_PAD_EOT2], `DSP_SEL_ALT1)) begin
      next_out[`DSP_PAD_EOT2] = periph_parity_out_i[2];
      next_oe[`DSP_PAD_EOT2]  = periph_parity_oe_i[2];
    end else if (both_sel(pad_cfg_i[`DSP_PAD_EOT2], `DSP_SEL_ALT2)) begin
      next_out[`DSP_PAD_EOT2] = terminal_count_out_i[2];
      next_oe[`DSP_PAD_EOT2]  = eot_direction_select_i[2];
    end
    // Channel 3 end-of-transfer pad; its request pad is input only
    if (both_sel(pad_cfg_i[`DSP_PAD_EOT3], `DSP_SEL_ALT2)) begin
      next_out[`DSP_PAD_EOT3] = terminal_count_out_i[3];
      next_oe[`DSP_PAD_EOT3]  = eot_direction_select_i[3];
    end
    // Chip selects 1:2 share pads with NAND enables
    for (int k = 1; k <= 2; k++) begin
      if (both_sel(pad_cfg_i[`DSP_PAD_CS1 + k - 1], `DSP_SEL_ALT1)) begin
        next_out[`DSP_PAD_CS1 + k - 1] = nand_ce_grouping_i[k-1] ?
          nand_chip_enable_n_i[k] : periph_chip_select_n_i[k];
        next_oe[`DSP_PAD_CS1 + k - 1]  = 1'b1;
      end
    end
  end

  // Registered pad drive; reset leaves every shared pad released as GPIO and drives the CS0 pad high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_o   <= '0;
      pad_oe_o    <= '0;
      cs0_pad_n_o <= 1'b1;
    end else begin
      pad_out_o   <= next_out;
      pad_oe_o    <= next_oe;
      cs0_pad_n_o <= nand_cs0_grouping_i ? nand_chip_enable0_n_i
                                         : periph_chip_select0_n_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input routing from synchronised pads
  localparam int REQ_PAD [4] = '{`DSP_PAD_REQ0, `DSP_PAD_REQ1, `DSP_PAD_REQ2,
                                 `DSP_PAD_REQ3};
  localparam int XFER_END_PAD [4] = '{`DSP_PAD_EOT0, `DSP_PAD_EOT1, `DSP_PAD_EOT2,
                                 `DSP_PAD_EOT3};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_request_o        <= '0;
      end_of_transfer_in_o <= '0;
      periph_parity_in_o   <= '0;
      gpio_in_o            <= '0;
    end else begin
      gpio_in_o <= pad_sync;
      for (int c = 0; c < NCH; c++) begin
        dma_request_o[c] <= pad_cfg_i[REQ_PAD[c]].input_select == `DSP_ISEL_ALT
                            && pad_cfg_i[REQ_PAD[c]].tristate_select == `DSP_SEL_ALT2
                            && pad_sync[REQ_PAD[c]];
        // Output mode masks the input so a terminal count cannot end its own channel
        end_of_transfer_in_o[c] <= !eot_direction_select_i[c]
                            && pad_cfg_i[XFER_END_PAD[c]].input_select == `DSP_ISEL_ALT
                            && pad_sync[XFER_END_PAD[c]];
      end
      periph_parity_in_o[0] <= pad_sync[`DSP_PAD_REQ2];
      periph_parity_in_o[1] <= pad_sync[`DSP_PAD_ACK2];
      periph_parity_in_o[2] <= pad_sync[`DSP_PAD_EOT2];
    end
  end

  // Address 05:07 gated per pad, 08:31 always through
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_address_o <= '0;
    end else begin
      periph_address_o        <= periph_address_i;
      periph_address_o[0]     <= next_out[`DSP_PAD_REQ0]
                                 & both_sel(pad_cfg_i[`DSP_PAD_REQ0], `DSP_SEL_ALT1);
      periph_address_o[1]     <= periph_address_i[1]
                                 & both_sel(pad_cfg_i[`DSP_PAD_ACK0], `DSP_SEL_ALT1);
      periph_address_o[2]     <= periph_address_i[2]
                                 & both_sel(pad_cfg_i[`DSP_PAD_EOT0], `DSP_SEL_ALT1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_XFER_END_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
    eot_direction_select_i[0] |=> !end_of_transfer_in_o[0])
    else $error("end of transfer seen while in output mode");
  AST_TCOUNT_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    both_sel(pad_cfg_i[`DSP_PAD_EOT3], `DSP_SEL_ALT2) && eot_direction_select_i[3]
    |=> pad_oe_o[`DSP_PAD_EOT3] && pad_out_o[`DSP_PAD_EOT3] == $past(terminal_count_out_i[3]))
    else $error("terminal count not driven");
  AST_XFER_END_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
    !eot_direction_select_i[2] |=> !pad_oe_o[`DSP_PAD_EOT2]
      || $past(pad_cfg_i[`DSP_PAD_EOT2].output_select) == `DSP_SEL_ALT1)
    else $error("end of transfer pad driven in input mode");
  AST_CS1_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
    !nand_ce_grouping_i[0] && both_sel(pad_cfg_i[`DSP_PAD_CS1], `DSP_SEL_ALT1)
    |=> pad_oe_o[`DSP_PAD_CS1] && pad_out_o[`DSP_PAD_CS1] == $past(periph_chip_select_n_i[1]))
    else $error("chip select 1 not routed");
  AST_CS0_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
    !nand_cs0_grouping_i |=> cs0_pad_n_o == $past(periph_chip_select0_n_i))
    else $error("chip select 0 not routed");
  AST_ADDR_MSB: assert property (@(posedge clk_i) disable iff (rst_i)
    !both_sel(pad_cfg_i[`DSP_PAD_REQ0], `DSP_SEL_ALT1) |=> !periph_address_o[0])
    else $error("address 05 present while unselected");
  AST_ADDR_LSB: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> periph_address_o[26] == $past(periph_address_i[26]))
    else $error("address 31 not passed");
  AST_GPIO_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    pad_cfg_i[`DSP_PAD_CS2].output_select == `DSP_SEL_GPIO |=> !pad_oe_o[`DSP_PAD_CS2])
    else $error("general purpose pad driven");

endmodule : dsp_pin_mux

// ===== sim/dsp_pad_partner.sv
/*
  Far-side model of the shared pads: external requesters and bus devices.
  Assumes one level per pad; the mux drive wins where both sides drive.
*/
`timescale 1ns/1ps
module dsp_pad_partner (
  input  wire logic [12:0] pad_out_i,
  input  wire logic [12:0] pad_oe_i,
  input  wire logic [12:0] ext_val_i,
  input  wire logic [12:0] ext_en_i,
  output logic      [12:0] pad_level_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Pull-up on undriven pads, as chip selects and boot address lines need
  always_comb begin
    for (int k = 0; k < 13; k++) begin
      if (pad_oe_i[k])
        pad_level_o[k] = pad_out_i[k];
      else if (ext_en_i[k])
        pad_level_o[k] = ext_val_i[k];
      else
        pad_level_o[k] = 1'h1;
    end
  end
endmodule : dsp_pad_partner

// ===== sim/tb_dsp_pin_mux.sv
/*
  Directed bench for the shared pad mux.
  Assumes the far-side model resolves pad levels; outputs are settled levels.
*/
`timescale 1ns/1ps
`include "dsp_consts.svh"
module tb_dsp_pin_mux;
  logic                  clk_i = 1'h0;
  logic                  rst_i = 1'h1;
  dsp_pkg::dsp_pad_cfg_t cfg [13];
  logic [3:0]            dir, ack, tcnt, req, xend;
  logic [2:0]            grp, par_in, ppo, ppoe;
  logic                  grp0, cs0_n, nce0_n, cs0_pad;
  logic [0:26]           addr, addr_o;
  logic [1:5]            cs_n;
  logic [1:2]            nce_n;
  logic [12:0]           pout, poe, pin, ext_v, ext_en, gin;
  int                    n_mismatch = 0;
  int                    compares = 0;
  int                    p;
  int eotp [4] = '{`DSP_PAD_EOT0, `DSP_PAD_EOT1, `DSP_PAD_EOT2, `DSP_PAD_EOT3};
  int reqp [4] = '{`DSP_PAD_REQ0, `DSP_PAD_REQ1, `DSP_PAD_REQ2, `DSP_PAD_REQ3};
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  dsp_pin_mux i_dsp_pin_mux (.clk_i(clk_i), .rst_i(rst_i), .pad_cfg_i(cfg),
    .eot_direction_select_i(dir), .nand_ce_grouping_i(grp), .nand_cs0_grouping_i(grp0),
    .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe), .dma_acknowledge_i(ack),
    .terminal_count_out_i(tcnt), .periph_address_i(addr), .periph_parity_out_i(ppo),
    .periph_parity_oe_i(ppoe), .periph_chip_select_n_i(cs_n), .nand_chip_enable_n_i(nce_n),
    .periph_chip_select0_n_i(cs0_n), .nand_chip_enable0_n_i(nce0_n), .cs0_pad_n_o(cs0_pad),
    .dma_request_o(req), .end_of_transfer_in_o(xend), .periph_parity_in_o(par_in),
    .gpio_in_o(gin), .periph_address_o(addr_o));
  dsp_pad_partner i_dsp_pad_partner (.pad_out_i(pout), .pad_oe_i(poe), .ext_val_i(ext_v),
    .ext_en_i(ext_en), .pad_level_o(pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %b expected %b", $time, got, exp);
    end
  endtask : chk
  task automatic setp(input int k, input logic [1:0] o, input logic [1:0] t,
                      input logic [1:0] i);
    cfg[k] = '{output_select: o, tristate_select: t, input_select: i};
  endtask : setp
  // Pad inputs need 3 edges; 4 leaves margin
  task automatic settle;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic wrap_up;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    foreach (cfg[k]) cfg[k] = '0;
    {dir, ack, tcnt, grp, grp0} = '0;
    {ppo, ppoe} = '0;
    {cs0_n, nce0_n, cs_n, nce_n} = '1;
    addr = '0;
    ext_v = '0;
    ext_en = '0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(poe === 13'h0000, 1'h1);
    chk(cs0_pad, 1'h1);
    rst_i = 1'h0;
    for (int c = 0; c < 4; c++) begin
      p = eotp[c];
      setp(p, 2'h2, 2'h2, 2'h1);
      dir[c] = 1'h1;
      tcnt[c] = 1'h1;
      settle();
      chk(poe[p], 1'h1);
      chk(pout[p], 1'h1);
      chk(xend[c], 1'h0);
      tcnt[c] = 1'h0;
      settle();
      chk(pout[p], 1'h0);
      dir[c] = 1'h0;
      ext_en[p] = 1'h1;
      ext_v[p] = 1'h1;
      settle();
      chk(poe[p], 1'h0);
      chk(xend[c], 1'h1);
      ext_v[p] = 1'h0;
      settle();
      chk(xend[c], 1'h0);
      ext_en[p] = 1'h0;
      setp(p, 2'h0, 2'h0, 2'h0);
    end
    // Request input, acknowledge output, then back to plain pins
    setp(0, 2'h0, 2'h2, 2'h1);
    setp(1, 2'h2, 2'h2, 2'h0);
    ext_en[0] = 1'h1;
    ext_v[0] = 1'h1;
    ack[0] = 1'h1;
    settle();
    chk(req[0], 1'h1);
    chk(pout[1], 1'h1);
    setp(0, 2'h0, 2'h0, 2'h0);
    setp(1, 2'h0, 2'h0, 2'h0);
    settle();
    chk(req[0], 1'h0);
    chk(poe[1], 1'h0);
    chk(gin[0], 1'h1);
    // Requests 1:3 need the DMA tristate select as well as the input select
    for (int c = 1; c < 4; c++) begin
      p = reqp[c];
      setp(p, 2'h0, 2'h2, 2'h1);
      ext_en[p] = 1'h1;
      ext_v[p] = 1'h1;
      settle();
      chk(req[c], 1'h1);
      chk(poe[p], 1'h0);
      setp(p, 2'h0, 2'h0, 2'h1);
      settle();
      chk(req[c], 1'h0);
      ext_en[p] = 1'h0;
    end
    // Acknowledge 1:2, then parity on the channel 2 pads
    ack[2:1] = 2'h1;
    setp(`DSP_PAD_ACK1, 2'h2, 2'h2, 2'h0);
    setp(`DSP_PAD_ACK2, 2'h2, 2'h2, 2'h0);
    settle();
    chk(pout[`DSP_PAD_ACK1], 1'h1);
    chk(poe[`DSP_PAD_ACK2], 1'h1);
    chk(pout[`DSP_PAD_ACK2], 1'h0);
    for (int k = 6; k < 9; k++) setp(k, 2'h1, 2'h1, 2'h0);
    ppo = 3'h5;
    ppoe = 3'h3;
    ext_en[8] = 1'h1;
    ext_v[8] = 1'h0;
    settle();
    chk(poe[6], 1'h1);
    chk(pout[6], 1'h1);
    chk(pout[7], 1'h0);
    chk(poe[8], 1'h0);
    chk(par_in[0], 1'h1);
    chk(par_in[1], 1'h0);
    chk(par_in[2], 1'h0);
    for (int k = 4; k < 9; k++) setp(k, 2'h0, 2'h0, 2'h0);
    ext_en[8] = 1'h0;
    settle();
    chk(par_in[2], 1'h1);
    // Address 05:07 on pads as pattern 101, address 31 passed through
    for (int k = 0; k < 3; k++) setp(k, 2'h1, 2'h1, 2'h0);
    ext_en[0] = 1'h0;
    addr[0] = 1'h1;
    addr[2] = 1'h1;
    addr[26] = 1'h1;
    settle();
    chk(pout[0], 1'h1);
    chk(pout[1], 1'h0);
    chk(pout[2], 1'h1);
    chk(poe[1], 1'h1);
    chk(addr_o[0], 1'h1);
    chk(addr_o[26], 1'h1);
    for (int k = 0; k < 3; k++) setp(k, 2'h0, 2'h0, 2'h0);
    settle();
    chk(addr_o[0], 1'h0);
    // Chip select against NAND enable on the CS1 pad
    setp(`DSP_PAD_CS1, 2'h1, 2'h1, 2'h0);
    cs_n[1] = 1'h0;
    settle();
    chk(poe[`DSP_PAD_CS1], 1'h1);
    chk(pout[`DSP_PAD_CS1], 1'h0);
    grp[0] = 1'h1;
    settle();
    chk(pout[`DSP_PAD_CS1], 1'h1);
    // Chip selects 2:5; grouping bit 2 blanks the shared request 1 pad
    for (int k = 3; k < 6; k++) setp(k, 2'h1, 2'h1, 2'h0);
    setp(`DSP_PAD_CS2, 2'h1, 2'h1, 2'h0);
    cs_n[2:5] = 4'h5;
    settle();
    chk(pout[`DSP_PAD_CS2], 1'h0);
    chk(pout[`DSP_PAD_REQ1], 1'h1);
    chk(poe[`DSP_PAD_REQ1], 1'h1);
    chk(pout[`DSP_PAD_ACK1], 1'h0);
    chk(pout[`DSP_PAD_EOT1], 1'h1);
    grp[2:1] = 2'h3;
    settle();
    chk(pout[`DSP_PAD_CS2], 1'h1);
    chk(poe[`DSP_PAD_REQ1], 1'h0);
    cs0_n = 1'h0;
    settle();
    chk(cs0_pad, 1'h0);
    grp0 = 1'h1;
    settle();
    chk(cs0_pad, 1'h1);
    wrap_up();
  end
endmodule : tb_dsp_pin_mux
